// ### src/stt_tap.sv
`timescale 1ns/100ps
module stt_tap #(
  parameter int DW = stt_pkg::DR_W
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // test bus
  input  wire stt_pkg::stt_tap_in_t  tap_in,
  output stt_pkg::stt_tap_out_t      tap_out,
  // functional data
  input  wire logic [DW-1:0]         func_in,
  output logic      [DW-1:0]         func_out,
  // status
  output logic [stt_pkg::IR_W-1:0]   instr_r,
  output logic                       bypass_r,
  output logic                       in_reset_r
);
  import stt_pkg::*;

  // ----------------------------------------
  // pin sampling and edge detect
  // ----------------------------------------
  stt_tap_in_t tap_s;
  logic [DW-1:0] func_s;
  logic tck_d_r;
  logic rise;
  logic fall;

  stt_sync #(.W(3)) u_sync_tap (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (tap_in),
    .q     (tap_s)
  );

  stt_sync #(.W(DW)) u_sync_func (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (func_in),
    .q     (func_s)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tap_s.tck;
    end
  end

  // edges are seen a few mclk late; tck must stay under about mclk/4
  assign rise = tap_s.tck & ~tck_d_r;
  assign fall = ~tap_s.tck & tck_d_r;

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  stt_state_t st_r;
  stt_state_t st_nxt;

  function automatic stt_state_t tap_next(input stt_state_t s, input logic tms);
    unique case (s)
      ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction

  assign st_nxt = tap_next(st_r, tap_s.tms);

  // tms is taken at the rise, relying on the controller moving it at the fall
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
    end else if (rise) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // state strobes
  // ----------------------------------------
  // register blocks test these strobes; the tdo mux and in_reset_r still compare st_r directly
  function automatic logic is_shift(input stt_state_t s);
    is_shift = (s == ST_SH_IR) || (s == ST_SH_DR);
  endfunction

  logic cap_ir_go;
  logic sh_ir_go;
  logic upd_ir_go;
  logic tlr_fall;
  logic cap_dr_go;
  logic sh_dr_go;
  logic upd_dr_fall;
  logic scan_fall;

  assign cap_ir_go   = rise & (st_r == ST_CAP_IR);
  assign sh_ir_go    = rise & (st_r == ST_SH_IR);
  assign upd_ir_go   = fall & (st_r == ST_UPD_IR);
  assign tlr_fall    = fall & (st_r == ST_RESET);
  assign cap_dr_go   = rise & (st_r == ST_CAP_DR);
  assign sh_dr_go    = rise & (st_r == ST_SH_DR);
  assign upd_dr_fall = fall & (st_r == ST_UPD_DR);
  assign scan_fall   = fall & is_shift(st_r);

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [IR_W-1:0] ir_sh_r;
  logic            byp_sel;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (cap_ir_go) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (sh_ir_go) begin
      // the last bit goes in on the rise into exit1-ir
      ir_sh_r <= {tap_s.tdi, ir_sh_r[IR_W-1:1]};
    end
  end

  // reset state selects bypass so an idle part stays out of the way
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      instr_r <= IR_BYPASS;
    end else if (tlr_fall) begin
      instr_r <= IR_BYPASS;
    end else if (upd_ir_go) begin
      instr_r <= ir_sh_r;
    end
  end

  assign byp_sel = (instr_r == IR_BYPASS);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_r <= 1'b1;
    end else begin
      bypass_r <= byp_sel;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= (st_r == ST_RESET);
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  logic          byp_r;
  logic [DW-1:0] dr_sh_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      byp_r <= BYP_CAPTURE;
    end else if (cap_dr_go) begin
      byp_r <= BYP_CAPTURE;
    end else if (sh_dr_go) begin
      byp_r <= tap_s.tdi;
    end
  end

  // non-bypass instructions reach a plain capture/update data register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dr_sh_r <= '0;
    end else if (cap_dr_go && !byp_sel) begin
      dr_sh_r <= func_s;
    end else if (sh_dr_go && !byp_sel) begin
      dr_sh_r <= {tap_s.tdi, dr_sh_r[DW-1:1]};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      func_out <= '0;
    end else if (upd_dr_fall && !byp_sel) begin
      func_out <= dr_sh_r;
    end
  end

  // ----------------------------------------
  // tdo driver
  // ----------------------------------------
  logic tdo_bit;

  always_comb begin
    if (st_r == ST_SH_IR) begin
      tdo_bit = ir_sh_r[0];
    end else if (byp_sel) begin
      tdo_bit = byp_r;
    end else begin
      tdo_bit = dr_sh_r[0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tap_out <= '0;
    end else if (scan_fall) begin
      tap_out.tdo_oe <= 1'b1;
      tap_out.tdo_o  <= tdo_bit;
    end else if (fall) begin
      tap_out.tdo_oe <= 1'b0;
      tap_out.tdo_o  <= 1'b0;
    end
  end

endmodule // stt_tap

// ### src/stt_pkg.sv
package stt_pkg;

  // ----------------------------------------
  // instruction and bypass registers
  // ----------------------------------------
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [IR_W-1:0] IR_BYPASS  = 8'hff;
  localparam logic            BYP_CAPTURE = 1'b0;

  // ----------------------------------------
  // data register width (parallel stage)
  // ----------------------------------------
  localparam int DR_W = 8;

  // ----------------------------------------
  // clock and link
  // ----------------------------------------
  localparam int MCLK_MHZ       = 100;
  localparam int TCK_PERIOD_NS  = 80;

  // ----------------------------------------
  // tap states, one-hot
  // ----------------------------------------
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SH_DR   = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } stt_state_t;

  // ----------------------------------------
  // test bus pins
  // ----------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } stt_tap_in_t;

  typedef struct packed {
    logic tdo_o;
    logic tdo_oe;
  } stt_tap_out_t;

endpackage

// ### src/stt_sync.sv
`timescale 1ns/100ps
module stt_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // stt_sync

// ### sim/stt_tap_properties.sv
`timescale 1ns/100ps
module stt_tap_properties #(
  parameter int DW = 8
) (
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire stt_pkg::stt_tap_in_t  tap_in,
  input wire stt_pkg::stt_tap_out_t tap_out,
  input wire logic [DW-1:0]         func_in,
  input wire logic [DW-1:0]         func_out,
  input wire logic [stt_pkg::IR_W-1:0] instr_r,
  input wire logic                  bypass_r,
  input wire logic                  in_reset_r
);
  import stt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ------
  // checks
  // ------
  // outputs move some cycles after a fall, so the pin was low two and three edges back
  sequence s_tck_low;
    !$past(tap_in.tck, 2) && !$past(tap_in.tck, 3);
  endsequence
  a_tdo_on_fall: assert property ($changed(tap_out) |-> s_tck_low)
    else $error("tdo moved outside a tck fall");
  a_func_on_fall: assert property ($changed(func_out) |-> s_tck_low ##0 !bypass_r)
    else $error("func_out moved outside update");
  a_instr_on_fall: assert property ($changed(instr_r) |-> s_tck_low)
    else $error("instr moved outside a tck fall");
  a_byp_decode: assert property ($changed(instr_r) |=> bypass_r == (instr_r == IR_BYPASS))
    else $error("bypass decode wrong");
  a_byp_holds: assert property (bypass_r && $past(bypass_r) |-> $stable(func_out))
    else $error("func_out moved in bypass");
  a_reset_instr: assert property ($rose(in_reset_r) |-> ##[1:12] instr_r == IR_BYPASS)
    else $error("reset did not select bypass");
  a_quiet_reset: assert property (in_reset_r |-> !tap_out.tdo_oe)
    else $error("tdo driven in reset state");
  a_tdo_idle: assert property (!tap_out.tdo_oe |-> !tap_out.tdo_o)
    else $error("tdo not low while floated");
  a_step_on_rise: assert property ($changed(in_reset_r) |-> $past(tap_in.tck, 2))
    else $error("state moved without tck rise");
endmodule // stt_tap_properties

bind stt_tap stt_tap_properties #(.DW(DW)) u_props (
  .mclk(mclk), .rst_b(rst_b), .tap_in(tap_in), .tap_out(tap_out), .func_in(func_in),
  .func_out(func_out), .instr_r(instr_r), .bypass_r(bypass_r), .in_reset_r(in_reset_r)
);

// ### sim/stt_ctl_model.sv
`timescale 1ns/100ps
module stt_ctl_model (
  // clock
  input  wire logic                  mclk,
  // test bus
  output stt_pkg::stt_tap_in_t       tap_in,
  input  wire stt_pkg::stt_tap_out_t tap_out
);
  import stt_pkg::*;
  initial tap_in = '0;
  // tck stands low between steps; one step is one 80 ns tck cycle
  task automatic step(input logic tms, input logic tdi, output logic so, output logic oe);
    tap_in.tms = tms;
    tap_in.tdi = tdi;
    repeat (4) @(posedge mclk);
    #1;
    // a floated tdo reads as its pull-up level
    so = tap_out.tdo_oe ? tap_out.tdo_o : 1'b1;
    oe = tap_out.tdo_oe;
    tap_in.tck = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    tap_in.tck = 1'b0;
  endtask
endmodule // stt_ctl_model

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import stt_pkg::*;
  `define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
  logic            mclk;
  logic            rst_b;
  stt_tap_in_t     tap_in;
  stt_tap_out_t    tap_out;
  logic [DR_W-1:0] func_in;
  logic [DR_W-1:0] func_out;
  logic [IR_W-1:0] instr_r;
  logic            bypass_r;
  logic            in_reset_r;
  int              n_mismatch = 0;
  int              n_compared = 0;
  logic [7:0]      d;
  logic            a;
  logic            e;
  stt_tap u_dut (.mclk(mclk), .rst_b(rst_b), .tap_in(tap_in), .tap_out(tap_out),
    .func_in(func_in), .func_out(func_out), .instr_r(instr_r), .bypass_r(bypass_r),
    .in_reset_r(in_reset_r));
  stt_ctl_model u_ctl (.mclk(mclk), .tap_in(tap_in), .tap_out(tap_out));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ------
  // tasks
  // ------
  // starts and ends in idle; samples tdo before each shifting rise
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
                      output logic [7:0] dout, output logic oe_all, output logic oe_end);
    logic so;
    logic oe;
    dout = '0;
    oe_all = 1'b1;
    u_ctl.step(1'b1, 1'b0, so, oe);
    if (ir) u_ctl.step(1'b1, 1'b0, so, oe);
    u_ctl.step(1'b0, 1'b0, so, oe);
    u_ctl.step(1'b0, 1'b0, so, oe);
    for (int i = 0; i < n; i++) begin
      u_ctl.step(i == n - 1, din[i], so, oe);
      dout[i] = so;
      oe_all &= oe;
    end
    u_ctl.step(1'b1, 1'b0, so, oe_end);
    u_ctl.step(1'b0, 1'b0, so, oe);
  endtask
  task automatic t_ir;
    u_ctl.step(1'b0, 1'b0, d[0], a);
    `CHK("in reset", 1'b0, in_reset_r)
    scan(1'b1, 8, 8'h3c, d, a, e);
    `CHK("ir out", IR_CAPTURE, d)
    `CHK("ir oe", 1'b1, a)
    `CHK("ir oe end", 1'b0, e)
    `CHK("instr", 8'h3c, instr_r)
  endtask
  task automatic t_dr;
    func_in = 8'ha5;
    scan(1'b0, 8, 8'h5a, d, a, e);
    `CHK("dr out", 8'ha5, d)
    `CHK("dr oe", 2'b10, {a, e})
    `CHK("func out", 8'h5a, func_out)
  endtask
  task automatic t_byp;
    scan(1'b1, 8, 8'hff, d, a, e);
    `CHK("bypass", 1'b1, bypass_r)
    scan(1'b0, 4, 8'h05, d, a, e);
    `CHK("byp out", 8'h0a, d)
    `CHK("func hold", 8'h5a, func_out)
  endtask
  // five tms highs from shift-dr: the longest way back to reset
  task automatic t_tlr;
    scan(1'b1, 8, 8'h00, d, a, e);
    `CHK("instr zero", 8'h00, instr_r)
    u_ctl.step(1'b1, 1'b0, d[0], a);
    u_ctl.step(1'b0, 1'b0, d[0], a);
    u_ctl.step(1'b0, 1'b0, d[0], a);
    repeat (4) u_ctl.step(1'b1, 1'b0, d[0], a);
    `CHK("tlr early", 1'b0, in_reset_r)
    u_ctl.step(1'b1, 1'b0, d[0], a);
    `CHK("tlr", 1'b1, in_reset_r)
    u_ctl.step(1'b1, 1'b0, d[0], a);
    `CHK("tlr instr", 8'hff, instr_r)
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    rst_b = 1'b0;
    func_in = 8'h00;
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK("reset", 12'h003, {tap_out, func_out, bypass_r, in_reset_r})
    t_ir;
    t_dr;
    t_byp;
    t_tlr;
    give_verdict;
  end
endmodule // tb_top
